// File: hw/cbbce_pkg.sv
// Package of constants and types for the branch and bit-clear executor
package cbbce_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_OPCODE = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
  localparam logic [7:0] OFS_MEM_DATA = 8'h18;
  // Flag bit positions in the flags register
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_NEG_POS = 4;
  // Opcode patterns
  localparam logic [7:0] OP_BR_CARRY = 8'he2;
  localparam logic [7:0] OP_BR_NEG = 8'he6;
  localparam logic [3:0] OP_BIT_CLR = 4'h9;
  // Access bank split and its upper bank
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  // Values after reset
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] MEM_ADDR_RESET = 12'h000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'h0;
  // First phase, held while idle
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  // Operand fetch phase index, last phase index
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  // Word step of the program counter
  localparam logic [15:0] PC_STEP = 16'h0002;
  // Decoded instruction fields
  typedef struct packed {
    logic [3:0] top;
    logic [2:0] bit_sel;
    logic bank_acc;
    logic [7:0] low;
  } cbbce_op_type;
  // Executor states
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} cbbce_state_type;
endpackage : cbbce_pkg

// File: hw/cbbce_top.sv
// Executor for branch-on-carry, branch-on-negative and register bit clear
`timescale 1ns/1ns
module cbbce_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // All state lives in this module; the package holds only
  // constants and types, so the map can be read in one place
  // Architectural state
  logic [15:0] pc_r; // Program counter, address of current word
  logic carry_r; // Carry flag
  logic neg_r; // Negative flag
  logic [3:0] bank_r; // Bank select register
  logic [11:0] mem_addr_r; // Window pointer into data memory
  logic [7:0] mem [0:4095]; // Banked file registers
  cbbce_pkg::cbbce_op_type op_r; // Instruction under execution
  cbbce_pkg::cbbce_state_type state_r; // Executor state
  cbbce_pkg::cbbce_state_type state_nxt;
  logic [1:0] phase_r; // Q1..Q4 phase counter
  logic [7:0] latch_r; // Operand read in Q2
  logic taken_r; // Last executed instruction was a taken branch
  logic [31:0] prdata_r; // Read data held for the access phase
  logic err_r; // Unmapped address seen in setup

  // Bus phase decode; the slave never inserts wait states, so
  // every access cycle is also the completing cycle
  wire setup = psel & ~penable; // First cycle of a transfer
  wire access = psel & penable; // Completing cycle
  wire wr_acc = access & pwrite; // Write lands here
  wire idle = (state_r == cbbce_pkg::ST_IDLE); // Executor free
  // One-hot hits; unaligned or unknown offsets hit nothing
  wire hit_op = (paddr == cbbce_pkg::OFS_OPCODE);
  wire hit_pc = (paddr == cbbce_pkg::OFS_PC);
  wire hit_fl = (paddr == cbbce_pkg::OFS_FLAGS);
  wire hit_bk = (paddr == cbbce_pkg::OFS_BANK);
  wire hit_st = (paddr == cbbce_pkg::OFS_STATE);
  wire hit_ma = (paddr == cbbce_pkg::OFS_MEM_ADDR);
  wire hit_md = (paddr == cbbce_pkg::OFS_MEM_DATA);
  wire mapped = hit_op | hit_pc | hit_fl | hit_bk | hit_st | hit_ma | hit_md;
  // Software writes to machine state only land while idle, so a
  // poke from the bus can never tear an instruction in flight
  wire sw_wr = wr_acc & ~err_r & idle;
  // An opcode write is also the start strobe
  wire start = sw_wr & hit_op;

  // Instruction decode; branches match the whole high byte, while
  // bit clear matches only the top nibble, the rest of its high
  // byte carrying the bit number and the bank-access bit
  wire is_br_carry = ({op_r.top, op_r.bit_sel, op_r.bank_acc}
    == cbbce_pkg::OP_BR_CARRY);
  wire is_br_neg = ({op_r.top, op_r.bit_sel, op_r.bank_acc}
    == cbbce_pkg::OP_BR_NEG);
  wire is_clr = (op_r.top == cbbce_pkg::OP_BIT_CLR);
  // Any other opcode runs as a one-cycle no-op that steps the PC
  // branch taken on carry or negative condition
  wire take = (is_br_carry & carry_r) | (is_br_neg & neg_r);
  wire [15:0] offs2 = {{7{op_r.low[7]}}, op_r.low, 1'b0};
  wire [15:0] pc_seq = pc_r + cbbce_pkg::PC_STEP;
  // target from the advanced PC
  // PC is 16 bits and wraps; a carry out of the sum is dropped
  wire [15:0] pc_jump = pc_seq + offs2;
  // Low half of the access bank is bank 0, high half the top bank
  // fixed access bank split
  // bank select when access bit set
  wire [3:0] acc_bank = op_r.low[7] ? cbbce_pkg::ACCESS_HI_BANK
    : cbbce_pkg::ACCESS_LO_BANK;
  wire [3:0] eff_bank = op_r.bank_acc ? bank_r : acc_bank;
  wire [11:0] eff_addr = {eff_bank, op_r.low};
  wire [7:0] clr_mask = ~(8'h01 << op_r.bit_sel);
  // Last phase of the cycle: state steps, PC and memory update
  wire q4 = (phase_r == cbbce_pkg::PHASE_Q4);
  wire exec_q4 = (state_r == cbbce_pkg::ST_EXEC) & q4; // Execute Q4
  // Second phase of an execute cycle: operand fetch
  wire exec_q2 = (state_r == cbbce_pkg::ST_EXEC)
    & (phase_r == cbbce_pkg::PHASE_Q2);

  // Read mux, sampled at setup so data comes from a flop
  // Memory read is combinational: good enough here, but a real
  // RAM would need its address one cycle earlier
  wire [31:0] rd_mux =
    hit_op ? {16'h0000, op_r} :
    hit_pc ? {16'h0000, pc_r} :
    hit_fl ? {27'h0, neg_r, 3'h0, carry_r} :
    hit_bk ? {28'h0, bank_r} :
    hit_st ? {27'h0, taken_r, phase_r, state_r} :
    hit_ma ? {20'h0, mem_addr_r} :
    hit_md ? {24'h0, mem[mem_addr_r]} : 32'h0;

  // Zero-wait answer; slave never stalls
  // Error shows only in the access phase, never during setup,
  // and a refused write leaves every register as it was
  assign pready = access;
  assign pslverr = access & err_r;
  assign prdata = prdata_r;

  // State sequencing; each busy state lasts one instruction cycle
  // of four clocks
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cbbce_pkg::ST_IDLE: begin
        // Only a software opcode write starts work
        if (start) state_nxt = cbbce_pkg::ST_EXEC;
      end
      cbbce_pkg::ST_EXEC: begin
        if (q4) state_nxt = take ? cbbce_pkg::ST_NOP : cbbce_pkg::ST_IDLE;
      end
      cbbce_pkg::ST_NOP: begin
        // Dummy cycle of a taken branch; nothing else moves
        if (q4) state_nxt = cbbce_pkg::ST_IDLE;
      end
      // Unused encoding falls back to idle
      default: state_nxt = cbbce_pkg::ST_IDLE;
    endcase
  end

  // Bus capture of read data and error; taking it in setup puts
  // read data on a flop, at the cost that a STATE read shows the
  // phase of the setup cycle rather than of the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= cbbce_pkg::RDATA_RESET;
      err_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= mapped ? rd_mux : 32'h0;
      err_r <= ~mapped;
    end
  end

  // State and phase; phase free-runs only while busy. Holding it
  // at Q1 while idle makes the first clock after the opcode write
  // always Q1, whatever the previous instruction did
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cbbce_pkg::ST_IDLE;
      phase_r <= cbbce_pkg::PHASE_Q1;
    end else begin
      state_r <= state_nxt;
      phase_r <= idle ? cbbce_pkg::PHASE_Q1 : phase_r + 2'h1;
    end
  end

  // Opcode, bank and pointer registers
  // Writes while busy are dropped without an error response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= '0;
      bank_r <= cbbce_pkg::BANK_RESET;
      mem_addr_r <= cbbce_pkg::MEM_ADDR_RESET;
    end else if (sw_wr) begin
      if (hit_op) op_r <= pwdata[15:0];
      if (hit_bk) bank_r <= pwdata[3:0];
      if (hit_ma) mem_addr_r <= pwdata[11:0];
    end
  end

  // Program counter, flags and taken status
  // Only software moves the flags; the executor never sets them
  // A Q4 update and a software write never meet: writes need idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= cbbce_pkg::PC_RESET;
      carry_r <= cbbce_pkg::FLAG_RESET;
      neg_r <= cbbce_pkg::FLAG_RESET;
      taken_r <= cbbce_pkg::FLAG_RESET;
    end else if (exec_q4) begin
      pc_r <= take ? pc_jump : pc_seq;
      taken_r <= take;
    end else if (sw_wr) begin
      if (hit_pc) pc_r <= pwdata[15:0];
      if (hit_fl) carry_r <= pwdata[cbbce_pkg::FLAG_CARRY_POS];
      if (hit_fl) neg_r <= pwdata[cbbce_pkg::FLAG_NEG_POS];
    end
  end

  // Operand latch; flags untouched by bit clear. Holding the
  // operand across Q3 gives the Q4 write-back a stable value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= cbbce_pkg::LATCH_RESET;
    end else if (exec_q2 && is_clr) begin
      latch_r <= mem[eff_addr];
    end
  end

  // Data memory; no reset so it maps to RAM
  // Bit-clear write-back comes first; software writes cannot
  // clash with it, as they are refused while busy
  always_ff @(posedge pclk) begin
    if (exec_q4 && is_clr) begin
      mem[eff_addr] <= latch_r & clr_mask;
    end else if (sw_wr && hit_md) begin
      mem[mem_addr_r] <= pwdata[7:0];
    end
  end
endmodule : cbbce_top

// File: tb/cbbce_sva.sv
// Port assertions for the branch and bit-clear executor
`timescale 1ns/1ns
module cbbce_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read setup cycle
  wire rs = psel && !penable && !pwrite;
  ready_now_a: assert property (pready == (psel && penable))
    else $error("ready off");
  err_in_access_a: assert property (pslverr |-> pready)
    else $error("stray error");
  unmapped_read_a: assert property (rs && paddr > 8'h18 ##1 pready
    |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h18
    && paddr[1:0] == 2'h0 ##1 pready |-> !pslverr) else $error("bad error");
  pc_width_a: assert property (rs && paddr == 8'h04 ##1 pready
    |-> prdata[31:16] == 16'h0) else $error("pc width");
  state_code_a: assert property (rs && paddr == 8'h10 ##1 pready
    |-> prdata[1:0] != 2'h3 && prdata[31:5] == 0) else $error("state code");
  flag_bits_a: assert property (rs && paddr == 8'h08 ##1 pready
    |-> (prdata & ~32'h11) == 32'h0) else $error("flag bits");
  reset_zero_a: assert property ($rose(presetn) |-> prdata == 0)
    else $error("reset data");
  cover property (pslverr);
  cover property (rs && paddr == 8'h10);
  cover property (psel && pwrite && paddr == 8'h00 ##1 pready);
endmodule : cbbce_sva
bind cbbce_top cbbce_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// File: tb/tb_top.sv
// Bench for the branch and bit-clear executor
`timescale 1ns/1ns
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tk, er;
  logic pready, pslverr;
  logic [7:0] paddr = 8'h00, rnd = 8'h49; // LFSR seed 73
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int errors = 0, n_compared = 0, polls, pc = 0, fl, ea, d;
  always #5 pclk = ~pclk;
  cbbce_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // A hang counts as a mismatch
  task automatic print_verdict(input int hung);
    errors += hung;
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    errors += (got !== exp);
    if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
  endtask : cmp
  // Request held until pready, a gap cycle before the next
  task automatic apb(input logic w, input logic [7:0] a, input int v);
    int i = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 9);
    if (i >= 9) print_verdict(1);
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask : apb
  // Opcode, then STATE polled until idle
  task automatic run(input logic [15:0] op);
    apb(1'b1, cbbce_pkg::OFS_OPCODE, op);
    for (polls = 1; polls < 9; polls++) begin
      apb(1'b0, cbbce_pkg::OFS_STATE, 0);
      if (rd[1:0] === 2'h0) break;
    end
    if (polls >= 9) print_verdict(1);
  endtask : run
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Both branch opcodes under every flag pair
    for (int k = 0; k < 8; k++) begin
      fl = {k[1], 3'h0, k[0]};
      apb(1'b1, cbbce_pkg::OFS_FLAGS, fl);
      rnd = lfsr(rnd);
      tk = k[2] ? k[1] : k[0];
      run({k[2] ? cbbce_pkg::OP_BR_NEG : cbbce_pkg::OP_BR_CARRY, rnd});
      cmp(rd[4], tk);
      cmp(polls, tk ? 4 : 2);
      pc = pc + 2 + (tk ? 2 * $signed(rnd) : 0);
      apb(1'b0, cbbce_pkg::OFS_PC, 0);
      cmp(rd, pc[15:0]);
    end
    // Bank register never equals the access bank used
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      apb(1'b1, cbbce_pkg::OFS_BANK, {~rnd[7], 3'h3});
      ea = k[0] ? {~rnd[7], 3'h3, rnd} : {{4{rnd[7]}}, rnd};
      apb(1'b1, cbbce_pkg::OFS_MEM_ADDR, ea);
      d = lfsr(rnd);
      apb(1'b1, cbbce_pkg::OFS_MEM_DATA, d);
      run({cbbce_pkg::OP_BIT_CLR, k[2:0], k[0], rnd});
      cmp(polls, 2);
      apb(1'b0, cbbce_pkg::OFS_MEM_DATA, 0);
      cmp(rd, d & ~(1 << k));
    end
    // Eight bit clears, each stepping the PC by one word
    pc = pc + 16;
    apb(1'b0, cbbce_pkg::OFS_PC, 0);
    cmp(rd, pc[15:0]);
    apb(1'b0, cbbce_pkg::OFS_FLAGS, 0);
    cmp(rd, fl);
    apb(1'b1, 8'h1c, -1);
    cmp(er, 1'b1);
    apb(1'b0, 8'h1c, 0);
    cmp(rd, 0);
    print_verdict(0);
  end
endmodule : tb_top
